/* File: rtl/fdi_pkg.sv */
// Constants, types and timing figures shared by the floppy drive interface
// Function
// - Density output high for 500K, 1M, 2M rates; low for 250K, 300K.
// - Direction output active steps head inward, inactive steps outward.
// - Drive select output low while control bit 0 selects drive zero.
// - Rate indicator shows bit 0 of last written rate register.
// - Side select output low for side 1, high for side 0.
// - Motor output low while control bit 4 is set, high otherwise.
// - Step pulses issued at a software programmed rate during a seek.
// - Write data leaves precompensated; amount chosen by software.
// - Write gate only enables writing, glitch free, off during power changes.
// - Timing derives from 48 MHz generator fed by 14.31818 MHz clock; the code times everything from the 50 MHz CLK_HZ instead.
package fdi_pkg;

  // ****************************************************************
  // Clocking
  // ****************************************************************
  localparam int REF_CLK_HZ = 14_318_180;
  localparam int GEN_CLK_HZ = 48_000_000;
  localparam int CLK_HZ     = 50_000_000;
  localparam int CLK_MHZ    = CLK_HZ / 1_000_000;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int STEP_UNIT_US   = 500;
  localparam int STEP_UNIT_CYC  = STEP_UNIT_US * CLK_MHZ;
  localparam int STEP_PULSE_NS  = 1000;
  localparam int STEP_PULSE_CYC = (STEP_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int WPULSE_NS      = 200;
  localparam int WPULSE_CYC     = (WPULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int PC_UNIT_NS     = 20;
  localparam int PC_UNIT_CYC    = (PC_UNIT_NS * CLK_MHZ + 999) / 1000;
  localparam int PC_BASE_CYC    = 8;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int DCTL_SEL_BIT = 0;
  localparam int DCTL_MTR_BIT = 4;
  localparam int RATE_LSB     = 0;
  localparam int PC_LSB       = 2;
  localparam int PC_SEL_W     = 3;
  localparam logic [7:0] DCTL_RST = 8'h00;
  localparam logic [2:0] PC_RST   = 3'h0;
  localparam int NUM_PINS     = 6;

  typedef enum logic [1:0] {
    RATE_500K = 2'b00,
    RATE_300K = 2'b01,
    RATE_250K = 2'b10,
    RATE_1M2M = 2'b11
  } fdi_rate_t;

  localparam fdi_rate_t RATE_RST = RATE_250K;

  typedef enum logic [1:0] {
    SK_IDLE  = 2'b00,
    SK_PULSE = 2'b01,
    SK_GAP   = 2'b10
  } fdi_seek_t;

endpackage

/* File: rtl/fdi_precomp.sv */
// Write pulse precompensation delay line
module fdi_precomp
  import fdi_pkg::*;
#(
  parameter int PC_W = PC_SEL_W
) (
  input  wire logic            clk,
  input  wire logic            arst_n,
  input  wire logic            flux,
  input  wire logic            early,
  input  wire logic            late,
  input  wire logic [PC_W-1:0] amount,
  output logic                 wr_out
);
  localparam int DLY = PC_BASE_CYC + 2;

  logic       busy_reg;
  logic [4:0] cnt_reg;
  logic [4:0] wcnt_reg;
  logic       out_reg;
  logic [4:0] shift;
  logic [4:0] load;

  assign shift = 5'(amount * PC_UNIT_CYC);
  always_comb begin
    load = 5'(PC_BASE_CYC);
    if (early && !late) begin
      load = 5'(PC_BASE_CYC) - shift;
    end else if (late && !early) begin
      load = 5'(PC_BASE_CYC) + shift;
    end
  end

  // A flux event while one is pending is dropped; bit cells are far longer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_reg <= 1'b0;
      cnt_reg  <= '0;
    end else if (!busy_reg) begin
      busy_reg <= flux;
      cnt_reg  <= load;
    end else if (cnt_reg == 5'h00) begin
      busy_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg - 5'h01;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_reg  <= 1'b0;
      wcnt_reg <= '0;
    end else if (busy_reg && cnt_reg == 5'h00) begin
      out_reg  <= 1'b1;
      wcnt_reg <= 5'(WPULSE_CYC - 1);
    end else if (wcnt_reg != 5'h00) begin
      wcnt_reg <= wcnt_reg - 5'h01;
    end else begin
      out_reg <= 1'b0;
    end
  end

  assign wr_out = out_reg;

  AST_PC_NOMINAL: assert property (@(posedge clk) disable iff (!arst_n)
    flux && !busy_reg && !early && !late |-> ##DLY $rose(out_reg))
    else $error("nominal write pulse delay wrong");
endmodule

/* File: rtl/fdi_step_if.sv */
// Seek request and step status between the control and the step engine
interface fdi_step_if;
  logic       start;
  logic       inward;
  logic [7:0] count;
  logic [3:0] rate;
  logic       home;
  logic       busy;
  logic       step;
  logic       done;

  modport ctl (output start, inward, count, rate, home, input busy, step, done);
  modport eng (input start, inward, count, rate, home, output busy, step, done);
endinterface

/* File: rtl/fdi_stepper.sv */
// Step pulse engine for head seeks
module fdi_stepper
  import fdi_pkg::*;
#(
  parameter int STEP_UNIT = STEP_UNIT_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  fdi_step_if.eng  sif
);
  localparam int PW1 = STEP_PULSE_CYC - 1;

  fdi_seek_t   state_reg;
  logic [19:0] tmr_reg;
  logic [7:0]  left_reg;
  logic        in_reg;
  logic        done_reg;
  logic [19:0] gap_cyc;
  logic        stop_now;

  // Slow rates give long gaps; 16 minus the rate code, in step units
  assign gap_cyc  = 20'((5'd16 - {1'b0, sif.rate}) * STEP_UNIT - 1);
  assign stop_now = (left_reg == 8'h00) || (sif.home && !in_reg);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= SK_IDLE;
      tmr_reg   <= '0;
      left_reg  <= '0;
      in_reg    <= 1'b0;
    end else begin
      case (state_reg)
        SK_IDLE: begin
          if (sif.start) begin
            left_reg <= sif.count;
            in_reg   <= sif.inward;
            tmr_reg  <= 20'(PW1);
            if (sif.count != 8'h00 && !(sif.home && !sif.inward)) begin
              state_reg <= SK_PULSE;
            end
          end
        end
        SK_PULSE: begin
          if (tmr_reg == 20'h00000) begin
            state_reg <= SK_GAP;
            tmr_reg   <= gap_cyc;
            left_reg  <= left_reg - 8'h01;
          end else begin
            tmr_reg <= tmr_reg - 20'h00001;
          end
        end
        SK_GAP: begin
          if (tmr_reg != 20'h00000) begin
            tmr_reg <= tmr_reg - 20'h00001;
          end else if (stop_now) begin
            state_reg <= SK_IDLE;
          end else begin
            state_reg <= SK_PULSE;
            tmr_reg   <= 20'(PW1);
          end
        end
        default: state_reg <= SK_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= (state_reg == SK_GAP && tmr_reg == 20'h00000 && stop_now)
                | (state_reg == SK_IDLE && sif.start
                   && (sif.count == 8'h00 || (sif.home && !sif.inward)));
    end
  end

  assign sif.step = (state_reg == SK_PULSE);
  assign sif.busy = (state_reg != SK_IDLE);
  assign sif.done = done_reg;

  AST_STEP_WIDTH: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(sif.step) |-> ##PW1 sif.step ##1 !sif.step)
    else $error("step pulse width wrong");

  AST_HOME_STOP: assert property (@(posedge clk) disable iff (!arst_n)
    state_reg == SK_IDLE && sif.start && sif.home && !sif.inward |=> !sif.step [*2])
    else $error("outward seek stepped past home");
endmodule

/* File: rtl/fdi_top.sv */
// Drive side signal logic of the floppy controller
module fdi_top
  import fdi_pkg::*;
#(
  parameter int STEP_UNIT = STEP_UNIT_CYC
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       dctl_wr,
  input  wire logic [7:0] dctl_data,
  input  wire logic       cfg_wr,
  input  wire logic [7:0] cfg_data,
  input  wire logic       dsr_wr,
  input  wire logic [7:0] dsr_data,
  input  wire logic       side1_sel,
  input  wire logic       seek_start,
  input  wire logic       seek_inward,
  input  wire logic [7:0] seek_steps,
  input  wire logic [3:0] step_rate,
  input  wire logic       write_req,
  input  wire logic       wr_flux,
  input  wire logic       wr_early,
  input  wire logic       wr_late,
  input  wire logic       index_in,
  input  wire logic       home_track_in,
  input  wire logic       write_protect_in,
  input  wire logic       media_change_in,
  input  wire logic       raw_read_in,
  input  wire logic       power_good_in,
  output logic            density_select_out,
  output logic            head_dir_n,
  output logic            drive_select_zero_n,
  output logic            rate_indicator_bit,
  output logic            side_select_out_n,
  output logic            motor_on_zero_n,
  output logic            step_n,
  output logic            write_data_n,
  output logic            write_enable_gate_n,
  output logic            index_pulse,
  output logic            home_track_stat,
  output logic            write_protect_stat,
  output logic            media_change_stat,
  output logic            raw_read_data,
  output logic            raw_read_edge,
  output logic            seek_busy,
  output logic            seek_done
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [NUM_PINS-1:0] pin_in;
  logic [NUM_PINS-1:0] sync1_reg;
  logic [NUM_PINS-1:0] sync2_reg;
  logic                idx_s;
  logic                trk_s;
  logic                wp_s;
  logic                chg_s;
  logic                rd_s;
  logic                pwr_s;

  assign pin_in = {power_good_in, raw_read_in, media_change_in,
                   write_protect_in, home_track_in, index_in};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_sync
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= pin_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  assign idx_s = sync2_reg[0];
  assign trk_s = sync2_reg[1];
  assign wp_s  = sync2_reg[2];
  assign chg_s = sync2_reg[3];
  assign rd_s  = sync2_reg[4];
  assign pwr_s = sync2_reg[5];

  // ****************************************************************
  // Control registers
  // ****************************************************************
  logic [7:0]          dctl_reg;
  fdi_rate_t           rate_reg;
  logic [PC_SEL_W-1:0] pc_reg;
  logic                drv_on;
  logic                mtr_on;
  logic                high_rate;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dctl_reg <= DCTL_RST;
    end else if (dctl_wr) begin
      dctl_reg <= dctl_data;
    end
  end

  // Same-cycle writes: the rate select register is taken as the later one
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rate_reg <= RATE_RST;
    end else if (dsr_wr) begin
      rate_reg <= fdi_rate_t'(dsr_data[RATE_LSB +: 2]);
    end else if (cfg_wr) begin
      rate_reg <= fdi_rate_t'(cfg_data[RATE_LSB +: 2]);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pc_reg <= PC_RST;
    end else if (dsr_wr) begin
      pc_reg <= dsr_data[PC_LSB +: PC_SEL_W];
    end
  end

  assign drv_on    = dctl_reg[DCTL_SEL_BIT];
  assign mtr_on    = dctl_reg[DCTL_MTR_BIT];
  assign high_rate = (rate_reg == RATE_500K) || (rate_reg == RATE_1M2M);

  // ****************************************************************
  // Static drive outputs
  // ****************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      drive_select_zero_n <= 1'b1;
      motor_on_zero_n     <= 1'b1;
      side_select_out_n   <= 1'b1;
      density_select_out  <= 1'b0;
      rate_indicator_bit  <= 1'b0;
    end else begin
      drive_select_zero_n <= ~drv_on;
      motor_on_zero_n     <= ~mtr_on;
      side_select_out_n   <= ~side1_sel;
      density_select_out  <= high_rate;
      rate_indicator_bit  <= rate_reg[RATE_LSB];
    end
  end

  // ****************************************************************
  // Seek
  // ****************************************************************
  fdi_step_if sif ();

  assign sif.start  = seek_start && !sif.busy;
  assign sif.inward = seek_inward;
  assign sif.count  = seek_steps;
  assign sif.rate   = step_rate;
  assign sif.home   = trk_s;

  fdi_stepper #(
    .STEP_UNIT (STEP_UNIT)
  ) u_stepper (
    .clk    (clk),
    .arst_n (arst_n),
    .sif    (sif)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      head_dir_n <= 1'b1;
    end else if (sif.start) begin
      head_dir_n <= ~seek_inward;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      step_n    <= 1'b1;
      seek_busy <= 1'b0;
      seek_done <= 1'b0;
    end else begin
      step_n    <= ~sif.step;
      seek_busy <= sif.busy;
      seek_done <= sif.done;
    end
  end

  // ****************************************************************
  // Write path
  // ****************************************************************
  logic pc_out;
  logic wg_next;

  fdi_precomp #(
    .PC_W (PC_SEL_W)
  ) u_precomp (
    .clk    (clk),
    .arst_n (arst_n),
    .flux   (wr_flux),
    .early  (wr_early),
    .late   (wr_late),
    .amount (pc_reg),
    .wr_out (pc_out)
  );

  // Gate built only from synchronised levels and one flop: no decode glitch
  assign wg_next = write_req && drv_on && mtr_on && pwr_s && !wp_s;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      write_enable_gate_n <= 1'b1;
      write_data_n        <= 1'b1;
    end else begin
      write_enable_gate_n <= ~wg_next;
      write_data_n        <= ~(pc_out && wg_next);
    end
  end

  // ****************************************************************
  // Drive status
  // ****************************************************************
  logic idx_prev_reg;
  logic rd_prev_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      idx_prev_reg       <= 1'b0;
      rd_prev_reg        <= 1'b0;
      index_pulse        <= 1'b0;
      home_track_stat    <= 1'b0;
      write_protect_stat <= 1'b0;
      media_change_stat  <= 1'b0;
      raw_read_data      <= 1'b0;
      raw_read_edge      <= 1'b0;
    end else begin
      idx_prev_reg       <= idx_s;
      rd_prev_reg        <= rd_s;
      index_pulse        <= idx_s && !idx_prev_reg;
      home_track_stat    <= trk_s;
      write_protect_stat <= wp_s;
      media_change_stat  <= chg_s;
      raw_read_data      <= rd_s;
      raw_read_edge      <= rd_s && !rd_prev_reg;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_DENSITY: assert property (@(posedge clk) disable iff (!arst_n)
    dsr_wr && (dsr_data[1:0] == RATE_500K || dsr_data[1:0] == RATE_1M2M)
    |-> ##2 density_select_out)
    else $error("density not high for high rate");

  AST_DIR: assert property (@(posedge clk) disable iff (!arst_n)
    seek_start && !sif.busy |=> head_dir_n == !$past(seek_inward))
    else $error("head direction mismatch");

  AST_DRV_SEL: assert property (@(posedge clk) disable iff (!arst_n)
    dctl_wr && dctl_data[DCTL_SEL_BIT] |-> ##2 !drive_select_zero_n)
    else $error("drive select not asserted");

  AST_RATE_CFG: assert property (@(posedge clk) disable iff (!arst_n)
    cfg_wr && !dsr_wr |-> ##2 rate_indicator_bit == $past(cfg_data[RATE_LSB], 2))
    else $error("rate indicator mismatch");

  AST_SIDE: assert property (@(posedge clk) disable iff (!arst_n)
    side1_sel |=> !side_select_out_n)
    else $error("side select not low for side 1");

  AST_MOTOR: assert property (@(posedge clk) disable iff (!arst_n)
    dctl_wr && !dctl_data[DCTL_MTR_BIT] |-> ##2 motor_on_zero_n)
    else $error("motor on while bit clear");

  AST_WG_PROT: assert property (@(posedge clk) disable iff (!arst_n)
    write_protect_stat || !write_enable_gate_n && !$past(pwr_s) |-> write_enable_gate_n)
    else $error("write gate active when forbidden");

  AST_STEP_OUT: assert property (@(posedge clk) disable iff (!arst_n)
    !step_n |-> seek_busy)
    else $error("step pulse outside a seek");

  AST_DENS_LOW: assert property (@(posedge clk) disable iff (!arst_n)
    dsr_wr && (dsr_data[1:0] == RATE_300K || dsr_data[1:0] == RATE_250K)
    |-> ##2 !density_select_out)
    else $error("density high for low rate");

  AST_RATE_DSR: assert property (@(posedge clk) disable iff (!arst_n)
    dsr_wr |-> ##2 rate_indicator_bit == $past(dsr_data[RATE_LSB], 2))
    else $error("rate indicator not following rate select");

  AST_WDATA_GATED: assert property (@(posedge clk) disable iff (!arst_n)
    !write_data_n |-> !write_enable_gate_n)
    else $error("write data outside write gate");

  // Power loss must close the gate within one edge of the synced level
  AST_WG_PWR: assert property (@(posedge clk) disable iff (!arst_n)
    !pwr_s |=> write_enable_gate_n)
    else $error("write gate active without power good");

  COV_HOME: cover property (@(posedge clk) disable iff (!arst_n) seek_done && home_track_stat);
  COV_SEEK: cover property (@(posedge clk) disable iff (!arst_n) seek_done);
  COV_WRITE: cover property (@(posedge clk) disable iff (!arst_n)
    !write_enable_gate_n && !write_data_n);
  COV_DENS: cover property (@(posedge clk) disable iff (!arst_n) $fell(density_select_out));
endmodule

/* File: tb/fdi_drive_model.sv */
// Behavioural single floppy drive on the far side of the interface
module fdi_drive_model #(
  parameter int INDEX_PER = 192
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic drive_select_zero_n,
  input  wire logic motor_on_zero_n,
  input  wire logic step_n,
  input  wire logic head_dir_n,
  input  wire logic protect_set,
  input  wire logic door_open,
  output logic      index_in,
  output logic      home_track_in,
  output logic      write_protect_in,
  output logic      media_change_in,
  output logic      raw_read_in
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] track_reg;
  logic [7:0] spin_reg;
  logic       step_d_reg;
  logic       sel;
  logic       spin;

  assign sel  = ~drive_select_zero_n;
  assign spin = ~motor_on_zero_n;

  // ****************************************************************
  // Head position
  // ****************************************************************
  // Head moves on the leading edge of a step, never below track 0
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      track_reg  <= 8'h00;
      step_d_reg <= 1'b1;
    end else begin
      step_d_reg <= step_n;
      if (sel && step_d_reg && !step_n) begin
        if (!head_dir_n) begin
          track_reg <= track_reg + 8'h01;
        end else if (track_reg != 8'h00) begin
          track_reg <= track_reg - 8'h01;
        end
      end
    end
  end

  // ****************************************************************
  // Spindle
  // ****************************************************************
  // Period is a multiple of 16 so read edges per turn are whole
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      spin_reg <= 8'h00;
    end else if (spin) begin
      spin_reg <= (spin_reg == 8'(INDEX_PER - 1)) ? 8'h00 : spin_reg + 8'h01;
    end
  end

  assign index_in         = spin & (spin_reg < 8'h04);
  assign home_track_in    = sel & (track_reg == 8'h00);
  assign write_protect_in = sel & protect_set;
  assign media_change_in  = sel & door_open;
  assign raw_read_in      = spin & spin_reg[3];
endmodule

/* File: tb/tb_floppy_drive_interface.sv */
// Self-checking bench for the floppy drive interface block
`define CHK(w, e, g) begin compares++; if ((g) !== (e)) begin failures++; $display("[FAIL] %s expected %0h seen %0h", w, e, g); end end
module tb_floppy_drive_interface
  import fdi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int SU = 5;

  logic       clk, arst_n, dctl_wr, cfg_wr, dsr_wr, side1_sel, seek_start, seek_inward, write_req;
  logic       wr_flux, wr_early, wr_late, power_good_in, protect_set, door_open;
  logic [7:0] dctl_data, cfg_data, dsr_data, seek_steps;
  logic [3:0] step_rate;
  logic       index_in, home_track_in, write_protect_in, media_change_in, raw_read_in;
  logic       density_select_out, head_dir_n, drive_select_zero_n, rate_indicator_bit, side_select_out_n;
  logic       motor_on_zero_n, step_n, write_data_n, write_enable_gate_n, index_pulse, home_track_stat;
  logic       write_protect_stat, media_change_stat, raw_read_data, raw_read_edge, seek_busy, seek_done;
  int         failures = 0;
  int         compares = 0;

  fdi_top #(.STEP_UNIT(SU)) dut_u (
    .clk, .arst_n, .dctl_wr, .dctl_data, .cfg_wr, .cfg_data, .dsr_wr, .dsr_data, .side1_sel,
    .seek_start, .seek_inward, .seek_steps, .step_rate, .write_req, .wr_flux, .wr_early, .wr_late,
    .index_in, .home_track_in, .write_protect_in, .media_change_in, .raw_read_in, .power_good_in,
    .density_select_out, .head_dir_n, .drive_select_zero_n, .rate_indicator_bit, .side_select_out_n,
    .motor_on_zero_n, .step_n, .write_data_n, .write_enable_gate_n, .index_pulse, .home_track_stat,
    .write_protect_stat, .media_change_stat, .raw_read_data, .raw_read_edge, .seek_busy, .seek_done
  );

  fdi_drive_model drv_u (
    .clk, .arst_n, .drive_select_zero_n, .motor_on_zero_n, .step_n, .head_dir_n, .protect_set,
    .door_open, .index_in, .home_track_in, .write_protect_in, .media_change_in, .raw_read_in
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Static outputs settle one edge after the strobe edge
  task automatic wr(input int k, input logic [7:0] d);
    dctl_wr = (k == 0);
    cfg_wr = (k == 1);
    dsr_wr = (k == 2);
    {dctl_data, cfg_data, dsr_data} = {d, d, d};
    tick(1);
    {dctl_wr, cfg_wr, dsr_wr} = 3'h0;
    tick(2);
  endtask

  task automatic report_and_stop;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    `CHK("select", 1'b1, drive_select_zero_n)
    `CHK("motor", 1'b1, motor_on_zero_n)
    `CHK("gate", 1'b1, write_enable_gate_n)
    `CHK("step", 1'b1, step_n)
    `CHK("density", 1'b0, density_select_out)
  endtask

  task automatic t_dor;
    logic [7:0] v [4] = '{8'h11, 8'h10, 8'h01, 8'h00};
    foreach (v[i]) begin
      wr(0, v[i]);
      `CHK("select", ~v[i][0], drive_select_zero_n)
      `CHK("motor", ~v[i][4], motor_on_zero_n)
    end
  endtask

  // Alternating the two rate registers so the last writer must win
  task automatic t_rate;
    for (int c = 0; c < 8; c++) begin
      wr(1 + c[0], {6'h00, c[2:1]});
      `CHK("density", (c[2:1] == 2'b00) || (c[2:1] == 2'b11), density_select_out)
      `CHK("rate bit", c[1], rate_indicator_bit)
    end
  endtask

  task automatic t_side;
    side1_sel = 1'b1;
    tick(2);
    `CHK("side", 1'b0, side_select_out_n)
    side1_sel = 1'b0;
    tick(2);
    `CHK("side", 1'b1, side_select_out_n)
  endtask

  task automatic run_seek(input logic inw, input logic [7:0] n, input logic [3:0] r, input int exp_p);
    int   p, low, t, f1, f2;
    logic prev, b0;
    {p, low, f1, f2} = '0;
    prev = 1'b1;
    seek_inward = inw;
    seek_steps = n;
    step_rate = r;
    seek_start = 1'b1;
    tick(1);
    seek_start = 1'b0;
    for (t = 0; t < 3000 && seek_done !== 1'b1; t++) begin
      tick(1);
      if (t == 0) b0 = seek_busy;
      if (prev === 1'b1 && step_n === 1'b0) begin
        p++;
        if (p == 1) f1 = t;
        if (p == 2) f2 = t;
      end
      low += (step_n === 1'b0);
      prev = step_n;
    end
    `CHK("seek done", 1'b1, seek_done)
    `CHK("busy early", exp_p > 0, b0)
    `CHK("pulses", exp_p, p)
    `CHK("step low", exp_p * STEP_PULSE_CYC, low)
    `CHK("direction", ~inw, head_dir_n)
    if (p > 1) `CHK("step spacing", STEP_PULSE_CYC + (16 - int'(r)) * SU, f2 - f1)
    tick(1);
    `CHK("busy", 1'b0, seek_busy)
  endtask

  // Outward seek must stop at home; none leaves from home
  task automatic t_seek;
    wr(0, 8'h01);
    run_seek(1'b1, 8'h03, 4'hF, 3);
    run_seek(1'b1, 8'h02, 4'hC, 2);
    run_seek(1'b0, 8'h08, 4'hF, 5);
    `CHK("home", 1'b1, home_track_stat)
    run_seek(1'b0, 8'h04, 4'hF, 0);
    run_seek(1'b1, 8'h00, 4'hF, 0);
  endtask

  task automatic flux(input logic e, input logic l, input int exp_d);
    int t, w;
    wr_early = e;
    wr_late = l;
    wr_flux = 1'b1;
    tick(1);
    wr_flux = 1'b0;
    for (t = 0; t < 40 && write_data_n !== 1'b0; t++) tick(1);
    for (w = 0; w < 40 && write_data_n === 1'b0; w++) tick(1);
    `CHK("flux delay", exp_d, t)
    `CHK("flux width", WPULSE_CYC, w)
    tick(20);
  endtask

  task automatic t_write;
    int n;
    wr(0, 8'h11);
    wr(2, 8'h08);
    power_good_in = 1'b1;
    write_req = 1'b1;
    tick(5);
    `CHK("gate", 1'b0, write_enable_gate_n)
    // Two edges of pipeline beyond the base delay; amount 2 from the rate select write
    flux(1'b0, 1'b0, PC_BASE_CYC + 2);
    flux(1'b1, 1'b0, PC_BASE_CYC + 2 - 2 * PC_UNIT_CYC);
    flux(1'b0, 1'b1, PC_BASE_CYC + 2 + 2 * PC_UNIT_CYC);
    flux(1'b1, 1'b1, PC_BASE_CYC + 2);
    protect_set = 1'b1;
    tick(5);
    `CHK("protect", 1'b1, write_protect_stat)
    `CHK("gate", 1'b1, write_enable_gate_n)
    wr_flux = 1'b1;
    tick(1);
    wr_flux = 1'b0;
    n = 0;
    repeat (30) begin
      tick(1);
      n += (write_data_n !== 1'b1);
    end
    `CHK("blocked data", 0, n)
    protect_set = 1'b0;
    power_good_in = 1'b0;
    tick(5);
    `CHK("gate", 1'b1, write_enable_gate_n)
    power_good_in = 1'b1;
    wr(0, 8'h10);
    tick(2);
    `CHK("gate", 1'b1, write_enable_gate_n)
    write_req = 1'b0;
  endtask

  task automatic t_status;
    int ni, ne, nr;
    wr(0, 8'h11);
    door_open = 1'b1;
    tick(5);
    `CHK("change", 1'b1, media_change_stat)
    door_open = 1'b0;
    tick(5);
    `CHK("change", 1'b0, media_change_stat)
    {ni, ne, nr} = '0;
    repeat (384) begin
      tick(1);
      ni += (index_pulse === 1'b1);
      ne += (raw_read_edge === 1'b1);
      nr += (raw_read_data === 1'b1);
    end
    `CHK("index", 2, ni)
    `CHK("read edges", 24, ne)
    `CHK("read level", 192, nr)
  endtask

  // ****************************************************************
  // Run
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Whole run is well under ten thousand cycles
  initial begin
    #1_000_000;
    failures++;
    report_and_stop();
  end

  initial begin
    {arst_n, dctl_wr, cfg_wr, dsr_wr, side1_sel, seek_start, seek_inward, write_req} = '0;
    {wr_flux, wr_early, wr_late, power_good_in, protect_set, door_open} = '0;
    {dctl_data, cfg_data, dsr_data, seek_steps, step_rate} = '0;
    tick(4);
    t_reset();
    arst_n = 1'b1;
    tick(1);
    t_reset();
    t_dor();
    t_rate();
    t_side();
    t_seek();
    t_write();
    t_status();
    report_and_stop();
  end
endmodule
